/* File: verilog/sbst_defines.vh */
// Purpose: Constants for the SRAM boundary-scan test access port.
// Assumes: Included by the tap module and the testbench.
// Notes:   Identity fields are arbitrary neutral values.
`ifndef SBST_DEFINES_VH
`define SBST_DEFINES_VH
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SBST_OP_EXTEST    4'h0
`define SBST_OP_SAMPLE    4'h1
`define SBST_OP_READ_ID   4'h2
`define SBST_OP_HIGHZ     4'h3
`define SBST_OP_CLAMP     4'h8
`define SBST_OP_CAPTURE   4'hD
`define SBST_OP_BYPASS    4'hF
`define SBST_IR_RESET     4'hF
// Idle levels of {trst_n, tck, tms, tdi}: test clock low, mode select high.
`define SBST_PIN_IDLE     4'hA
// ----------------------------------------
// Identification fields (values arbitrary)
// ----------------------------------------
`define SBST_ID_REV       4'h1
`define SBST_ID_PART      16'h0ABC
`define SBST_ID_VENDOR    11'h055
// ----------------------------------------
// TAP states
// ----------------------------------------
`define SBST_S_RESET      4'h0
`define SBST_S_IDLE       4'h1
`define SBST_S_SEL_DR     4'h2
`define SBST_S_CAP_DR     4'h3
`define SBST_S_SH_DR      4'h4
`define SBST_S_EX1_DR     4'h5
`define SBST_S_PA_DR      4'h6
`define SBST_S_EX2_DR     4'h7
`define SBST_S_UPD_DR     4'h8
`define SBST_S_SEL_IR     4'h9
`define SBST_S_CAP_IR     4'hA
`define SBST_S_SH_IR      4'hB
`define SBST_S_EX1_IR     4'hC
`define SBST_S_PA_IR      4'hD
`define SBST_S_EX2_IR     4'hE
`define SBST_S_UPD_IR     4'hF
`endif

/* File: verilog/sbst_tap.v */
// Purpose: Boundary-scan test access port sampled on the system clock.
// Assumes: Test clock far slower than clk; all test pins pass two flops.
// Notes:   Boundary chain length is a parameter; one cell per input pin, two per output pin.
`timescale 1ns/1ps
`include "sbst_defines.vh"
// Behaviour
// (RL1) Extest drives outputs from boundary cells
// (RL2) Sample captures pins into boundary chain
// (RL3) Preload shifts boundary cells, pins unaffected
// (RL4) Read-id captures identification into path
// (RL5) Highz selects bypass, outputs tristated
// (RL6) Clamp holds outputs from cells, bypass
// (RL7) Capture-ir loads code 1101
// (RL8) Bypass code gives one-bit path
// (RL9) Id holds revision, part, vendor fields
// (RL10) Id bit zero reads one
// (RL11) Power-up reset; test reset optional
// (RL12) Chain covers functional pins except test pins
// (RL13) Controller runs test clock at 10MHz; the bench controller uses a 48 ns period
// (RL14) Reserved codes select bypass, normal pins
// (RL15) Sixteen-state machine, tdo on falling edge
module sbst_tap #(
    parameter NIN  = 8,
    parameter NOUT = 8
) (
    input  wire            clk,
    input  wire            rst,
    input  wire            tck,
    input  wire            tms,
    input  wire            tdi,
    input  wire            trst_n,
    input  wire [NIN-1:0]  func_in,
    input  wire [NOUT-1:0] func_out,
    input  wire [NOUT-1:0] func_oe,
    output reg  [NIN-1:0]  core_in,
    output reg  [NOUT-1:0] pin_out,
    output reg  [NOUT-1:0] pin_oe,
    output reg             tdo,
    output reg             tdo_oe
);
    localparam NB = NIN + 2 * NOUT;
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [3:0] s1_q;
    reg [3:0] s2_q;
    reg       tck_prev_q;
    // Reset to the idle pin levels so that no false test clock edge follows reset.
    always @(posedge clk) begin
        if (rst) begin
            s1_q       <= `SBST_PIN_IDLE;
            s2_q       <= `SBST_PIN_IDLE;
            tck_prev_q <= 1'b0;
        end else begin
            s1_q       <= {trst_n, tck, tms, tdi};
            s2_q       <= s1_q;
            tck_prev_q <= s2_q[2];
        end
    end
    wire tms_s  = s2_q[1];
    wire tdi_s  = s2_q[0];
    wire trst_s = ~s2_q[3];
    wire rise   = s2_q[2] & ~tck_prev_q;
    wire fall   = ~s2_q[2] & tck_prev_q;
    // ----------------------------------------
    // State machine
    // ----------------------------------------
    reg [3:0] st_q;
    reg [3:0] st_d;
    always @* begin
        case (st_q)
            `SBST_S_RESET:  st_d = tms_s ? `SBST_S_RESET  : `SBST_S_IDLE;
            `SBST_S_IDLE:   st_d = tms_s ? `SBST_S_SEL_DR : `SBST_S_IDLE;
            `SBST_S_SEL_DR: st_d = tms_s ? `SBST_S_SEL_IR : `SBST_S_CAP_DR;
            `SBST_S_CAP_DR: st_d = tms_s ? `SBST_S_EX1_DR : `SBST_S_SH_DR;
            `SBST_S_SH_DR:  st_d = tms_s ? `SBST_S_EX1_DR : `SBST_S_SH_DR;
            `SBST_S_EX1_DR: st_d = tms_s ? `SBST_S_UPD_DR : `SBST_S_PA_DR;
            `SBST_S_PA_DR:  st_d = tms_s ? `SBST_S_EX2_DR : `SBST_S_PA_DR;
            `SBST_S_EX2_DR: st_d = tms_s ? `SBST_S_UPD_DR : `SBST_S_SH_DR;
            `SBST_S_UPD_DR: st_d = tms_s ? `SBST_S_SEL_DR : `SBST_S_IDLE;
            `SBST_S_SEL_IR: st_d = tms_s ? `SBST_S_RESET  : `SBST_S_CAP_IR;
            `SBST_S_CAP_IR: st_d = tms_s ? `SBST_S_EX1_IR : `SBST_S_SH_IR;
            `SBST_S_SH_IR:  st_d = tms_s ? `SBST_S_EX1_IR : `SBST_S_SH_IR;
            `SBST_S_EX1_IR: st_d = tms_s ? `SBST_S_UPD_IR : `SBST_S_PA_IR;
            `SBST_S_PA_IR:  st_d = tms_s ? `SBST_S_EX2_IR : `SBST_S_PA_IR;
            `SBST_S_EX2_IR: st_d = tms_s ? `SBST_S_UPD_IR : `SBST_S_SH_IR;
            `SBST_S_UPD_IR: st_d = tms_s ? `SBST_S_SEL_DR : `SBST_S_IDLE;
            default:        st_d = `SBST_S_RESET;
        endcase
    end
    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    reg [3:0] instruction_register_q;
    reg [3:0] ir_shift_q;
    // Path select: 0 bypass, 1 boundary chain, 2 identification.
    function [1:0] path_of;
        input [3:0] op;
        begin
            case (op)
                `SBST_OP_EXTEST:  path_of = 2'h1; // RL1
                `SBST_OP_SAMPLE:  path_of = 2'h1; // RL2
                `SBST_OP_READ_ID: path_of = 2'h2; // RL4
                default:          path_of = 2'h0; // RL5 RL6 RL8 RL14
            endcase
        end
    endfunction
    wire [1:0] path    = path_of(instruction_register_q);
    wire       drive_b = (instruction_register_q == `SBST_OP_EXTEST) |
                         (instruction_register_q == `SBST_OP_CLAMP); // RL1 RL6
    wire       hiz     = (instruction_register_q == `SBST_OP_HIGHZ); // RL5
    wire [31:0] id_word = {`SBST_ID_REV, `SBST_ID_PART, `SBST_ID_VENDOR, 1'b1}; // RL9 RL10
    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg [NB-1:0] bs_shift_q;
    reg [NB-1:0] bs_upd_q;
    reg [31:0]   id_shift_q;
    reg          bypass_register_q;
    wire         pin_reset = rst | trst_s; // RL11
    // Every state, instruction and data stage moves only on a detected test clock rise (tdo and tdo_oe on a fall), so a stopped
    // test clock leaves the port frozen with its pads in their last mode.
    always @(posedge clk) begin
        if (pin_reset) begin
            st_q <= `SBST_S_RESET;
        end else if (rise) begin
            st_q <= st_d; // RL15
        end
    end
    // ----------------------------------------
    // Instruction path
    // ----------------------------------------
    always @(posedge clk) begin
        if (pin_reset) begin
            instruction_register_q <= `SBST_IR_RESET;
            ir_shift_q             <= `SBST_IR_RESET;
        end else if (rise) begin
            case (st_q)
                `SBST_S_RESET:  instruction_register_q <= `SBST_IR_RESET;
                `SBST_S_CAP_IR: ir_shift_q <= `SBST_OP_CAPTURE; // RL7
                `SBST_S_SH_IR:  ir_shift_q <= {tdi_s, ir_shift_q[3:1]};
                `SBST_S_UPD_IR: instruction_register_q <= ir_shift_q;
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // Identification and bypass stages
    // ----------------------------------------
    always @(posedge clk) begin
        if (pin_reset) begin
            id_shift_q        <= 32'h0;
            bypass_register_q <= 1'b0;
        end else if (rise) begin
            if (st_q == `SBST_S_CAP_DR) begin
                bypass_register_q <= 1'b0;
                id_shift_q        <= id_word; // RL4
            end else if (st_q == `SBST_S_SH_DR) begin
                bypass_register_q <= tdi_s; // RL8
                id_shift_q        <= {tdi_s, id_shift_q[31:1]};
            end
        end
    end
    // ----------------------------------------
    // Boundary scan chain
    // ----------------------------------------
    // Only extest and sample route the chain, so other codes keep the cells.
    always @(posedge clk) begin
        if (pin_reset) begin
            bs_shift_q <= {NB{1'b0}};
            bs_upd_q   <= {NB{1'b0}};
        end else if (rise && (path == 2'h1)) begin
            case (st_q)
                `SBST_S_CAP_DR: bs_shift_q <= {func_oe, func_out, func_in}; // RL2 RL12
                `SBST_S_SH_DR:  bs_shift_q <= {tdi_s, bs_shift_q[NB-1:1]}; // RL3
                `SBST_S_UPD_DR: bs_upd_q   <= bs_shift_q; // RL3
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // Pad drivers
    // ----------------------------------------
    // Extest and clamp take each pad from its update cells; highz only
    // ever lowers the enable, so no pad can be driven by mistake.
    wire [NOUT-1:0] pin_out_d;
    wire [NOUT-1:0] pin_oe_d;
    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi = gi + 1) begin : g_pad
            assign pin_out_d[gi] = drive_b ? bs_upd_q[NIN + gi] : func_out[gi]; // RL1 RL6
            assign pin_oe_d[gi]  = ~hiz & (drive_b ? bs_upd_q[NIN + NOUT + gi] : func_oe[gi]); // RL5
        end
    endgenerate
    // ----------------------------------------
    // Serial output and pin muxing
    // ----------------------------------------
    reg ser_bit;
    always @* begin
        if (st_q == `SBST_S_SH_IR)
            ser_bit = ir_shift_q[0];
        else case (path)
            2'h1:    ser_bit = bs_shift_q[0];
            2'h2:    ser_bit = id_shift_q[0];
            default: ser_bit = bypass_register_q;
        endcase
    end
    always @(posedge clk) begin
        if (pin_reset) begin
            tdo     <= 1'b0;
            tdo_oe  <= 1'b0;
            core_in <= {NIN{1'b0}};
            pin_out <= {NOUT{1'b0}};
            pin_oe  <= {NOUT{1'b0}};
        end else begin
            if (fall) begin
                tdo    <= ser_bit; // RL15
                tdo_oe <= (st_q == `SBST_S_SH_DR) | (st_q == `SBST_S_SH_IR);
            end
            core_in <= func_in;
            pin_out <= pin_out_d; // RL1 RL6
            pin_oe  <= pin_oe_d; // RL5
        end
    end
endmodule // sbst_tap

/* File: tb/sbst_tap_properties.sv */
// Purpose: Port-level properties of the boundary-scan tap.
// Assumes: Test clock stays low for six clk cycles after each falling edge.
// Notes:   Bound to every tap instance.
`timescale 1ns/1ps
module sbst_tap_properties #(
    parameter NIN  = 8,
    parameter NOUT = 8
) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            tck,
    input wire logic            tms,
    input wire logic            tdi,
    input wire logic            trst_n,
    input wire logic            tdo,
    input wire logic            tdo_oe,
    input wire logic [NIN-1:0]  func_in,
    input wire logic [NIN-1:0]  core_in,
    input wire logic [NOUT-1:0] func_out,
    input wire logic [NOUT-1:0] func_oe,
    input wire logic [NOUT-1:0] pin_out,
    input wire logic [NOUT-1:0] pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence oe_held(logic v);
        (tdo_oe == v) [*8];
    endsequence
    reset_clears_out_a: assert property (disable iff (1'b0) rst |=> !tdo_oe && !tdo && pin_oe == '0)
        else $error("outputs not cleared by reset");
    core_follow_a: assert property (!rst && $past(trst_n, 2) |=> core_in == $past(func_in))
        else $error("core input copy wrong");
    tdo_on_fall_a: assert property ($changed(tdo) |-> !tck) else $error("tdo moved with tck high");
    oe_on_fall_a: assert property ($changed(tdo_oe) |-> !tck) else $error("tdo_oe moved with tck high");
    shift_held_a: assert property ($rose(tdo_oe) |-> oe_held(1'b1)) else $error("shift window too short");
    idle_held_a: assert property ($fell(tdo_oe) |-> oe_held(1'b0)) else $error("idle window too short");
    pin_follow_a: assert property ($changed(pin_out) && !tck && trst_n && $past(trst_n, 8)
        |-> pin_out == $past(func_out)) else $error("pin_out moved on its own");
    enable_follow_a: assert property ($changed(pin_oe) && !tck && trst_n && $past(trst_n, 8)
        |-> pin_oe == $past(func_oe)) else $error("pin_oe moved on its own");
endmodule // sbst_tap_properties
bind sbst_tap sbst_tap_properties #(.NIN(NIN), .NOUT(NOUT)) u_props (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .func_in(func_in), .core_in(core_in),
    .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe));

/* File: tb/sbst_ctrl.sv */
// Purpose: External test controller model driving the tap pins.
// Assumes: Test clock period 48 ns, held low between frames.
// Notes:   Shifts least significant bit first.
`timescale 1ns/1ps
module sbst_ctrl (
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck = 1'b0,
    output logic      tms = 1'b1,
    output logic      tdi = 1'b0,
    output logic      trst_n = 1'b1
);
    task step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (6) @(posedge clk);
        tck <= 1'b1;
        o = tdo;
        repeat (6) @(posedge clk);
        tck <= 1'b0;
    endtask
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
    task idle();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
    task treset();
        trst_n <= 1'b0;
        repeat (6) @(posedge clk);
        trst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule // sbst_ctrl

/* File: tb/tb_sram_boundary_scan_tap.sv */
// Purpose: Self-checking bench for the boundary-scan tap.
// Assumes: Default chain widths of eight inputs and eight outputs.
// Notes:   Chain order is enables, outputs, inputs, input bit zero first out.
`timescale 1ns/1ps
`include "sbst_defines.vh"
module tb_sram_boundary_scan_tap;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  func_in = 8'h96, func_out = 8'h5A, func_oe = 8'hC3, core_in, pin_out, pin_oe;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic [31:0] got;
    int          errors = 0;
    int          total_checks = 0;
    always #2 clk = ~clk;
    sbst_ctrl u_ctl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
    sbst_tap u_dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .func_in(func_in),
        .func_out(func_out), .func_oe(func_oe), .core_in(core_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .tdo(tdo), .tdo_oe(tdo_oe));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        total_checks++;
        if (act !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task ld(input logic [3:0] op);
        u_ctl.scan(1'b1, 4, {28'h0, op}, got);
        chk("ir capture", 32'hD, got);
    endtask
    task t_reset();
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pin_out", 32'(func_out), 32'(pin_out));
        chk("core_in", 32'(func_in), 32'(core_in));
        chk("tdo_oe", 32'h0, 32'(tdo_oe));
        u_ctl.idle();
        $display("reset test done");
    endtask
    task t_id();
        ld(`SBST_OP_READ_ID);
        u_ctl.scan(1'b0, 32, 32'h0, got);
        chk("id", {`SBST_ID_REV, `SBST_ID_PART, `SBST_ID_VENDOR, 1'b1}, got);
        $display("id test done");
    endtask
    task t_byp();
        logic [3:0] ops [3];
        ops = '{4'hF, 4'hE, 4'h3};
        foreach (ops[i]) begin
            ld(ops[i]);
            u_ctl.scan(1'b0, 8, 32'hA5, got);
            chk("bypass path", 32'h4A, got);
            chk("pin_oe", ops[i] == 4'h3 ? 32'h0 : 32'(func_oe), 32'(pin_oe));
        end
        $display("bypass test done");
    endtask
    task t_bsr();
        ld(`SBST_OP_SAMPLE);
        u_ctl.scan(1'b0, 24, 32'h0F3CE1, got);
        chk("capture", 32'({func_oe, func_out, func_in}), got);
        chk("preload pins", 32'(func_out), 32'(pin_out));
        ld(`SBST_OP_EXTEST);
        chk("extest out", 32'h3C, 32'(pin_out));
        chk("extest oe", 32'h0F, 32'(pin_oe));
        func_out <= 8'h11;
        ld(`SBST_OP_CLAMP);
        chk("clamp out", 32'h3C, 32'(pin_out));
        u_ctl.treset();
        chk("test reset", 32'h11, 32'(pin_out));
        $display("boundary test done");
    endtask
    task complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        t_reset();
        t_id();
        t_byp();
        t_bsr();
        complete_run();
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule // tb_sram_boundary_scan_tap
